//--- design/lab_top.sv
// LIN serial port: auto-baud, wake on break, break send and receive
`timescale 1ns/1ps
`default_nettype none
`include "lab_map.svh"
module lab_top
  import lab_pkg::*;
(
  input wire logic sys_clk, // 20 MHz clock
  input wire logic srst, // Sync reset, active high
  input wire lab_bus_t bus_i, // Register request
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic cpu_sleep, // Stops the base clock
  input wire logic rx_line, // Serial receive pin
  output logic tx_line, // Serial transmit pin
  output logic rx_flag, // Receive flag level
  output logic wake_event // One pulse per wake-up edge
);
  // ----------------------------------------------------------------------
  // Registers and pin sampling
  // ----------------------------------------------------------------------
  logic tx_en_q, send_break_q, hs_sel_q, port_en_q, rx_en_q;
  logic wide_sel_q, wake_en_q, cal_en_q, wake_seen_q;
  logic [15:0] div_q;
  logic [7:0] tx_buf_q, rx_data_q, rdata_q, rd_mux;
  logic tx_buf_full_q, frame_err_q, rx_flag_q, wake_event_q;
  logic rx_s1_q, rx_s2_q, rx_prev_q;
  logic base_tick, cal_tick, fall, rise;
  logic [15:0] eff_div;
  logic wr_tx_ctrl, wr_baud, wr_tx_data, rd_rx_data;
  lab_rx_st_t rx_st_q;
  lab_tx_st_t tx_st_q;
  lab_ab_st_t ab_st_q;
  logic [15:0] rx_cnt_q, tx_cnt_q;
  logic [3:0] rx_bits_q, tx_bits_q;
  logic [7:0] rx_shift_q, tx_shift_q;
  logic tx_brk_q, tx_out_q;
  logic [2:0] ab_edges_q;
  logic rx_run, rx_tick_end, tx_tick_end, tx_load, brk_done, ab_done;
  logic rx_done, wake_fall, wake_rise, ab_counting;

  assign wr_tx_ctrl = bus_i.wr && bus_i.addr == `LAB_OFF_TX_CTRL;
  assign wr_baud = bus_i.wr && bus_i.addr == `LAB_OFF_BAUD_CTRL;
  assign wr_tx_data = bus_i.wr && bus_i.addr == `LAB_OFF_TX_DATA;
  assign rd_rx_data = bus_i.rd && bus_i.addr == `LAB_OFF_RX_DATA;

  // Only the second stage and its delayed copy feed the edge logic
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_line;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end
  assign fall = rx_prev_q && !rx_s2_q;
  assign rise = !rx_prev_q && rx_s2_q;

  lab_tick u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(!cpu_sleep),
    .wide_sel(wide_sel_q),
    .hs_sel(hs_sel_q),
    .base_tick(base_tick),
    .cal_tick(cal_tick)
  );

  // Narrow mode ignores the high byte for bit timing
  assign eff_div = wide_sel_q ? div_q : {8'h00, div_q[7:0]};

  // ----------------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_en_q <= 1'b0;
      send_break_q <= 1'b0;
      hs_sel_q <= 1'b0;
    end else if (wr_tx_ctrl) begin
      tx_en_q <= bus_i.wdata[`LAB_TX_EN_BIT];
      send_break_q <= bus_i.wdata[`LAB_SEND_BRK_BIT];
      hs_sel_q <= bus_i.wdata[`LAB_HS_SEL_BIT];
    end else if (brk_done) begin
      send_break_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      port_en_q <= 1'b0;
      rx_en_q <= 1'b0;
    end else if (bus_i.wr && bus_i.addr == `LAB_OFF_RX_CTRL) begin
      port_en_q <= bus_i.wdata[`LAB_PORT_EN_BIT];
      rx_en_q <= bus_i.wdata[`LAB_RX_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wide_sel_q <= 1'b0;
      cal_en_q <= 1'b0;
    end else if (wr_baud) begin
      wide_sel_q <= bus_i.wdata[`LAB_WIDE_SEL_BIT];
      cal_en_q <= bus_i.wdata[`LAB_CAL_EN_BIT];
    end else if (ab_done) begin
      cal_en_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Wake on break
  // ----------------------------------------------------------------------
  assign wake_fall = wake_en_q && !wake_seen_q && fall;
  assign wake_rise = wake_en_q && wake_seen_q && rise;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wake_en_q <= 1'b0;
      wake_seen_q <= 1'b0;
    end else if (wr_baud) begin
      wake_en_q <= bus_i.wdata[`LAB_WAKE_EN_BIT];
      wake_seen_q <= 1'b0;
    end else if (wake_fall) begin
      wake_seen_q <= 1'b1;
    end else if (wake_rise) begin
      wake_en_q <= 1'b0;
      wake_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wake_event_q <= 1'b0;
    end else begin
      wake_event_q <= wake_fall;
    end
  end

  // ----------------------------------------------------------------------
  // Auto-baud measurement
  // ----------------------------------------------------------------------
  // Calibration waits for the break to end when wake is also armed
  assign ab_counting = ab_st_q == AB_COUNT;
  assign ab_done = ab_counting && rise &&
                   ab_edges_q == `LAB_CAL_EDGES_LAST;

  always_ff @(posedge sys_clk) begin
    if (srst || !cal_en_q) begin
      ab_st_q <= AB_IDLE;
      ab_edges_q <= 3'h0;
    end else begin
      unique case (ab_st_q)
        AB_IDLE: begin
          if (!wake_en_q && fall) begin
            ab_st_q <= AB_START;
          end
        end
        AB_START: begin
          if (rise) begin
            ab_st_q <= AB_COUNT;
            ab_edges_q <= 3'h1;
          end
        end
        AB_COUNT: begin
          if (ab_done) begin
            ab_st_q <= AB_IDLE;
          end else if (rise) begin
            ab_edges_q <= ab_edges_q + 3'h1;
          end
        end
      endcase
    end
  end

  // Divisor doubles as the counter; software writes lose during a count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_q <= `LAB_DIV_RST;
    end else if (ab_st_q == AB_START && rise) begin
      div_q <= 16'h0000;
    end else if (ab_counting) begin
      if (cal_tick) begin
        div_q <= div_q + 16'h0001;
      end
    end else if (bus_i.wr && bus_i.addr == `LAB_OFF_DIV_LOW) begin
      div_q[7:0] <= bus_i.wdata;
    end else if (bus_i.wr && bus_i.addr == `LAB_OFF_DIV_HIGH) begin
      div_q[15:8] <= bus_i.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  assign rx_run = port_en_q && rx_en_q && !cal_en_q && !wake_en_q;
  assign rx_tick_end = base_tick && rx_cnt_q == 16'h0000;
  assign rx_done = rx_st_q == RX_STOP && rx_tick_end;

  always_ff @(posedge sys_clk) begin
    if (srst || !rx_run) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_bits_q <= 4'h0;
      rx_shift_q <= `LAB_DATA_RST;
    end else begin
      if (rx_st_q == RX_IDLE) begin
        rx_cnt_q <= {1'b0, eff_div[15:1]};
      end else if (rx_tick_end) begin
        rx_cnt_q <= eff_div;
      end else if (base_tick) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end
      unique case (rx_st_q)
        RX_IDLE: begin
          if (fall) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick_end) begin
            rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
            rx_bits_q <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_tick_end) begin
            rx_shift_q <= {rx_s2_q, rx_shift_q[7:1]};
            rx_bits_q <= rx_bits_q + 4'h1;
            if (rx_bits_q == `LAB_DATA_BITS_LAST) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick_end) begin
            rx_st_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // A break reads back as 00h with framing_error set
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_data_q <= `LAB_DATA_RST;
      frame_err_q <= 1'b0;
    end else if (rx_done) begin
      rx_data_q <= rx_shift_q;
      frame_err_q <= !rx_s2_q;
    end
  end

  // Set beats a clear by a read in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_flag_q <= 1'b0;
    end else if (rx_done || wake_fall || ab_done) begin
      rx_flag_q <= 1'b1;
    end else if (rd_rx_data) begin
      rx_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  assign tx_tick_end = base_tick && tx_cnt_q == 16'h0000;
  assign tx_load = tx_st_q == TX_IDLE && tx_en_q && tx_buf_full_q;
  assign brk_done = tx_st_q == TX_STOP && tx_tick_end && tx_brk_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_buf_q <= `LAB_DATA_RST;
      tx_buf_full_q <= 1'b0;
    end else if (wr_tx_data) begin
      tx_buf_q <= bus_i.wdata;
      tx_buf_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_bits_q <= 4'h0;
      tx_shift_q <= `LAB_DATA_RST;
      tx_brk_q <= 1'b0;
      tx_out_q <= 1'b1;
    end else begin
      if (tx_load || tx_tick_end) begin
        tx_cnt_q <= eff_div;
      end else if (base_tick) begin
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end
      unique case (tx_st_q)
        TX_IDLE: begin
          if (tx_load) begin
            tx_st_q <= TX_START;
            tx_brk_q <= send_break_q;
            tx_shift_q <= send_break_q ? 8'h00 : tx_buf_q;
            tx_out_q <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_tick_end) begin
            tx_st_q <= TX_DATA;
            tx_bits_q <= 4'h0;
            tx_out_q <= tx_shift_q[0];
          end
        end
        TX_DATA: begin
          if (tx_tick_end) begin
            tx_bits_q <= tx_bits_q + 4'h1;
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            if (tx_bits_q == (tx_brk_q ? `LAB_BRK_BITS_LAST
                                       : `LAB_DATA_BITS_LAST)) begin
              tx_st_q <= TX_STOP;
              tx_out_q <= 1'b1;
            end else begin
              tx_out_q <= tx_shift_q[1];
            end
          end
        end
        TX_STOP: begin
          if (tx_tick_end) begin
            tx_st_q <= TX_IDLE;
            tx_brk_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_i.addr)
      `LAB_OFF_TX_CTRL: begin
        rd_mux[`LAB_TX_EN_BIT] = tx_en_q;
        rd_mux[`LAB_SEND_BRK_BIT] = send_break_q;
        rd_mux[`LAB_HS_SEL_BIT] = hs_sel_q;
        rd_mux[`LAB_TX_EMPTY_BIT] = tx_st_q == TX_IDLE;
      end
      `LAB_OFF_RX_CTRL: begin
        rd_mux[`LAB_PORT_EN_BIT] = port_en_q;
        rd_mux[`LAB_RX_EN_BIT] = rx_en_q;
        rd_mux[`LAB_FRAME_ERR_BIT] = frame_err_q;
      end
      `LAB_OFF_BAUD_CTRL: begin
        rd_mux[`LAB_RX_IDLE_BIT] = rx_st_q == RX_IDLE;
        rd_mux[`LAB_WIDE_SEL_BIT] = wide_sel_q;
        rd_mux[`LAB_WAKE_EN_BIT] = wake_en_q;
        rd_mux[`LAB_CAL_EN_BIT] = cal_en_q;
      end
      `LAB_OFF_DIV_LOW: rd_mux = div_q[7:0];
      `LAB_OFF_DIV_HIGH: rd_mux = div_q[15:8];
      `LAB_OFF_TX_DATA: rd_mux = 8'h00;
      `LAB_OFF_RX_DATA: rd_mux = rx_data_q;
      `LAB_OFF_FLAGS: begin
        rd_mux[`LAB_RX_FLAG_BIT] = rx_flag_q;
        rd_mux[`LAB_TXBUF_EMPTY_BIT] = !tx_buf_full_q;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (bus_i.rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign rdata = rdata_q;
  assign rx_flag = rx_flag_q;
  assign wake_event = wake_event_q;
  assign tx_line = tx_out_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_brk_stop;
    tx_st_q == TX_STOP && tx_tick_end && tx_brk_q;
  endsequence

  a_cal_rx_idle: assert property (@(posedge sys_clk) disable iff (srst)
    cal_en_q |=> rx_st_q == RX_IDLE)
    else $error("receiver active during calibration");
  a_cal_flags: assert property (@(posedge sys_clk) disable iff (srst)
    ab_done && !wr_baud |=> rx_flag_q && !cal_en_q)
    else $error("calibration end did not flag");
  a_rx_flag_read: assert property (@(posedge sys_clk) disable iff (srst)
    rd_rx_data && !rx_done && !wake_fall && !ab_done |=> !rx_flag_q)
    else $error("rx_flag not cleared by data read");
  a_cal_count_up: assert property (@(posedge sys_clk) disable iff (srst)
    ab_counting && cal_tick && !rise
      |=> div_q == $past(div_q) + 16'h0001)
    else $error("calibration counter did not advance");
  a_wake_rx_idle: assert property (@(posedge sys_clk) disable iff (srst)
    wake_en_q |=> rx_st_q == RX_IDLE)
    else $error("receiver active while wake armed");
  a_wake_flag: assert property (@(posedge sys_clk) disable iff (srst)
    wake_fall |=> rx_flag_q ##0 wake_event)
    else $error("wake edge did not flag");
  a_wake_clear: assert property (@(posedge sys_clk) disable iff (srst)
    wake_rise && !wr_baud |=> !wake_en_q)
    else $error("wake enable not cleared at break end");
  a_break_zeros: assert property (@(posedge sys_clk) disable iff (srst)
    tx_brk_q && (tx_st_q == TX_START || tx_st_q == TX_DATA) |-> !tx_line)
    else $error("break bit not zero");
  a_break_clear: assert property (@(posedge sys_clk) disable iff (srst)
    s_brk_stop ##0 !wr_tx_ctrl |=> !send_break_q ##0 tx_st_q == TX_IDLE)
    else $error("send_break not cleared after break");
  a_tx_busy: assert property (@(posedge sys_clk) disable iff (srst)
    tx_load |=> tx_st_q == TX_START ##0 !tx_line)
    else $error("load did not start a frame");
endmodule : lab_top
`default_nettype wire

//--- common/lab_map.svh
// Register offsets, field positions and reset values of the LIN serial port
`ifndef LAB_MAP_SVH
`define LAB_MAP_SVH
`define LAB_OFF_TX_CTRL 3'h0
`define LAB_OFF_RX_CTRL 3'h1
`define LAB_OFF_BAUD_CTRL 3'h2
`define LAB_OFF_DIV_LOW 3'h3
`define LAB_OFF_DIV_HIGH 3'h4
`define LAB_OFF_TX_DATA 3'h5
`define LAB_OFF_RX_DATA 3'h6
`define LAB_OFF_FLAGS 3'h7
`define LAB_TX_EN_BIT 5
`define LAB_SEND_BRK_BIT 3
`define LAB_HS_SEL_BIT 2
`define LAB_TX_EMPTY_BIT 1
`define LAB_PORT_EN_BIT 7
`define LAB_RX_EN_BIT 4
`define LAB_FRAME_ERR_BIT 2
`define LAB_RX_IDLE_BIT 6
`define LAB_WIDE_SEL_BIT 3
`define LAB_WAKE_EN_BIT 1
`define LAB_CAL_EN_BIT 0
`define LAB_RX_FLAG_BIT 0
`define LAB_TXBUF_EMPTY_BIT 1
`define LAB_DIV_RST 16'h0000
`define LAB_DATA_RST 8'h00
`define LAB_PRE_MASK_SLOW 6'h3f
`define LAB_PRE_MASK_MID 6'h0f
`define LAB_PRE_MASK_FAST 6'h03
`define LAB_CAL_DIV_LAST 3'h7
`define LAB_CAL_EDGES_LAST 3'h4
`define LAB_DATA_BITS_LAST 4'h7
`define LAB_BRK_BITS_LAST 4'hb
`endif

//--- common/lab_pkg.sv
// Types shared by the LIN serial port
package lab_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lab_bus_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} lab_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} lab_tx_st_t;
  typedef enum logic [1:0] {AB_IDLE, AB_START, AB_COUNT} lab_ab_st_t;
endpackage : lab_pkg

//--- design/lab_tick.sv
// Base clock prescaler and calibration clock divider
`timescale 1ns/1ps
`default_nettype none
`include "lab_map.svh"
module lab_tick
  import lab_pkg::*;
(
  input wire logic sys_clk, // 20 MHz clock
  input wire logic srst, // Sync reset
  input wire logic run, // Low stops ticks in sleep
  input wire logic wide_sel, // wide_divisor_sel
  input wire logic hs_sel, // high_speed_sel
  output logic base_tick, // Base clock pulse
  output logic cal_tick // Calibration clock pulse
);
  logic [5:0] pre_q;
  logic [2:0] cal_q;
  logic [5:0] mask;

  always_comb begin
    unique case ({wide_sel, hs_sel})
      2'b00: mask = `LAB_PRE_MASK_SLOW;
      2'b11: mask = `LAB_PRE_MASK_FAST;
      default: mask = `LAB_PRE_MASK_MID;
    endcase
  end

  assign base_tick = run && ((pre_q & mask) == mask);
  assign cal_tick = base_tick && (cal_q == `LAB_CAL_DIV_LAST);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre_q <= 6'h00;
    end else if (run) begin
      pre_q <= pre_q + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cal_q <= 3'h0;
    end else if (base_tick) begin
      cal_q <= cal_q + 3'h1;
    end
  end

  a_cal_eighth: assert property (@(posedge sys_clk) disable iff (srst)
    base_tick |=> cal_q == $past(cal_q) + 3'h1)
    else $error("calibration divider skipped a base tick");
endmodule : lab_tick
`default_nettype wire

//--- tb/lab_node.sv
// Remote serial node model: drives the receive pin, watches the transmit pin
`timescale 1ns/1ps
`default_nettype none
module lab_node (
  input wire logic sys_clk, // System clock
  input wire logic tx_line, // Device transmit pin
  output logic rx_line // Device receive pin, pulled up when idle
);
  initial rx_line = 1'b1;

  task automatic hold(input logic lvl, input int n, input int p);
    rx_line <= lvl;
    repeat (n * p) @(posedge sys_clk);
  endtask : hold

  // Wake character stays all zeros for its whole length
  task automatic send_break(input int n, input int p);
    hold(1'b0, n, p);
    hold(1'b1, 2, p);
  endtask : send_break

  task automatic send_byte(input logic [7:0] b, input int p);
    hold(1'b0, 1, p);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], 1, p);
    end
    hold(1'b1, 2, p);
  endtask : send_byte

  // Low time of a break, idle gap after it, then the following byte
  task automatic catch_hdr(input int p, output int low, output int gap,
                           output logic [7:0] b);
    low = 0;
    gap = 0;
    do @(posedge sys_clk); while (tx_line !== 1'b0);
    while (tx_line === 1'b0) begin
      @(posedge sys_clk);
      low++;
    end
    while (tx_line === 1'b1) begin
      @(posedge sys_clk);
      gap++;
    end
    repeat (p / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (p) @(posedge sys_clk);
      b[i] = tx_line;
    end
  endtask : catch_hdr
endmodule : lab_node
`default_nettype wire

//--- tb/lin_autobaud_wake_break_bench.sv
// Self-checking bench for the LIN serial port extensions
`timescale 1ns/1ps
`default_nettype none
`include "lab_map.svh"
module lin_autobaud_wake_break_bench
  import lab_pkg::*;
;
  localparam int BASE_FAST = 4;
  localparam int BASE_MID = 16;
  localparam int P_BIT = 40;
  localparam int P_FAST = 160;
  localparam int P_MID = 4160;
  // Eight bit times counted at one eighth of the base rate
  localparam int CNT_FAST = 8 * P_FAST / (8 * BASE_FAST);
  localparam int CNT_MID = 8 * P_MID / (8 * BASE_MID);
  logic sys_clk;
  logic srst;
  lab_bus_t bus;
  logic [7:0] rdata;
  logic cpu_sleep;
  logic rx_line;
  logic tx_line;
  logic rx_flag;
  logic wake_event;
  int error_cnt;
  int n_checks;
  int low;
  int gap;
  logic [7:0] rv;
  logic [7:0] sb;

  lab_top dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .bus_i(bus),
    .rdata(rdata),
    .cpu_sleep(cpu_sleep),
    .rx_line(rx_line),
    .tx_line(tx_line),
    .rx_flag(rx_flag),
    .wake_event(wake_event)
  );
  lab_node node (
    .sys_clk(sys_clk),
    .tx_line(tx_line),
    .rx_line(rx_line)
  );

  // ----------------------------------------
  // Checks and register access
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input int tol);
    n_checks++;
    if ((^seen === 1'bx) || (seen > exp + 16'(tol)) ||
        (seen + 16'(tol) < exp)) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input int t);
    rd(a, rv);
    chk({8'h00, rv}, {8'h00, e}, t);
  endtask : rchk

  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    bus = '0;
    cpu_sleep = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rchk(`LAB_OFF_TX_CTRL, 8'h02, 0);
    wr(`LAB_OFF_RX_CTRL, 8'h90);
    wr(`LAB_OFF_BAUD_CTRL, 8'h08);
    wr(`LAB_OFF_TX_CTRL, 8'h24);
    wr(`LAB_OFF_DIV_LOW, 8'(P_BIT / BASE_FAST - 1));
    wr(`LAB_OFF_DIV_HIGH, 8'h00);
    // Break seen by the ordinary receiver
    node.send_break(13, P_BIT);
    chk({15'h0, rx_flag}, 16'h0001, 0);
    rchk(`LAB_OFF_RX_CTRL, 8'h94, 0);
    rchk(`LAB_OFF_RX_DATA, 8'h00, 0);
    chk({15'h0, rx_flag}, 16'h0000, 0);
    // Break header followed straight by the sync byte
    wr(`LAB_OFF_TX_CTRL, 8'h2c);
    fork
      node.catch_hdr(P_BIT, low, gap, sb);
      begin
        wr(`LAB_OFF_TX_DATA, 8'ha5);
        wr(`LAB_OFF_TX_DATA, 8'h55);
        repeat (100) @(posedge sys_clk);
        rchk(`LAB_OFF_TX_CTRL, 8'h2c, 0);
      end
    join
    // Start bit waits for the first base tick, so it may end a little early
    chk(16'(low), 16'(13 * P_BIT - 2), 2);
    chk(16'(gap), 16'(P_BIT), 3);
    chk({8'h00, sb}, 16'h0055, 0);
    rchk(`LAB_OFF_TX_CTRL, 8'h24, 0);
    repeat (2 * P_BIT) @(posedge sys_clk);
    rchk(`LAB_OFF_TX_CTRL, 8'h26, 0);
    // Wake-up while asleep: clocks to the bit timing are stopped
    rchk(`LAB_OFF_BAUD_CTRL, 8'h48, 0);
    wr(`LAB_OFF_BAUD_CTRL, 8'h0a);
    cpu_sleep <= 1'b1;
    fork
      node.send_break(13, P_BIT);
      begin
        for (int n = 0; n < 400 && wake_event !== 1'b1; n++) begin
          @(posedge sys_clk);
          #1;
        end
        chk({15'h0, wake_event}, 16'h0001, 0);
        repeat (2) @(posedge sys_clk);
        chk({15'h0, rx_flag}, 16'h0001, 0);
        repeat (4 * P_BIT) @(posedge sys_clk);
        rchk(`LAB_OFF_BAUD_CTRL, 8'h4a, 0);
      end
    join
    cpu_sleep <= 1'b0;
    rchk(`LAB_OFF_BAUD_CTRL, 8'h48, 0);
    rd(`LAB_OFF_RX_DATA, rv);
    chk({15'h0, rx_flag}, 16'h0001 ^ 16'h0001, 0);
    // Calibration at the fastest base clock
    wr(`LAB_OFF_BAUD_CTRL, 8'h09);
    fork
      node.send_byte(8'h55, P_FAST);
      begin
        repeat (3 * P_FAST) @(posedge sys_clk);
        rchk(`LAB_OFF_BAUD_CTRL, 8'h49, 0);
      end
    join
    chk({15'h0, rx_flag}, 16'h0001, 0);
    rchk(`LAB_OFF_BAUD_CTRL, 8'h48, 0);
    rchk(`LAB_OFF_DIV_LOW, 8'(CNT_FAST), 1);
    rchk(`LAB_OFF_DIV_HIGH, 8'h00, 0);
    rd(`LAB_OFF_RX_DATA, rv);
    // Wake armed beside calibration: the byte after the break is measured
    wr(`LAB_OFF_BAUD_CTRL, 8'h0b);
    node.send_break(13, P_FAST);
    chk({15'h0, rx_flag}, 16'h0001, 0);
    rchk(`LAB_OFF_BAUD_CTRL, 8'h49, 0);
    rd(`LAB_OFF_RX_DATA, rv);
    chk({15'h0, rx_flag}, 16'h0000, 0);
    node.send_byte(8'h55, P_FAST);
    chk({15'h0, rx_flag}, 16'h0001, 0);
    rchk(`LAB_OFF_DIV_LOW, 8'(CNT_FAST), 1);
    rd(`LAB_OFF_RX_DATA, rv);
    // Narrow divisor mode still counts across both bytes
    wr(`LAB_OFF_BAUD_CTRL, 8'h01);
    node.send_byte(8'h55, P_MID);
    rchk(`LAB_OFF_DIV_LOW, 8'(CNT_MID), 1);
    rchk(`LAB_OFF_DIV_HIGH, 8'(CNT_MID >> 8), 0);
    rd(`LAB_OFF_RX_DATA, rv);
    chk({15'h0, rx_flag}, 16'h0000, 0);
    end_sim();
  end
endmodule : lin_autobaud_wake_break_bench
`default_nettype wire
